// ---- logic/cdr_pkg.sv ----
// Constants, types and register map of the converter result and calibration block
package cdr_pkg;

   // Register offsets on the two-wire bus address pointer
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CH1_RES_HI = 8'h01;
   localparam logic [7:0] ADDR_CH1_RES_LO = 8'h02;
   localparam logic [7:0] ADDR_CH2_RES_HI = 8'h03;
   localparam logic [7:0] ADDR_CH2_RES_LO = 8'h04;
   localparam logic [7:0] ADDR_CH1_ZERO_HI = 8'h05;
   localparam logic [7:0] ADDR_CH1_ZERO_LO = 8'h06;
   localparam logic [7:0] ADDR_CH2_ZERO_HI = 8'h07;
   localparam logic [7:0] ADDR_CH2_ZERO_LO = 8'h08;
   localparam logic [7:0] ADDR_CH1_SCALE_HI = 8'h09;
   localparam logic [7:0] ADDR_CH1_SCALE_LO = 8'h0A;
   localparam logic [7:0] ADDR_CH1_SETUP = 8'h0B;
   localparam logic [7:0] ADDR_CH2_SCALE_HI = 8'h0C;
   localparam logic [7:0] ADDR_CH2_SCALE_LO = 8'h0D;
   localparam logic [7:0] ADDR_CH2_SETUP = 8'h0E;

   // Field positions
   localparam int STAT_SLEEP_BIT = 7;
   localparam int STAT_LAST_CH_BIT = 2;
   localparam int STAT_CH2_PEND_BIT = 1;
   localparam int STAT_CH1_PEND_BIT = 0;
   localparam int SETUP_RANGE_LSB = 6;
   localparam int SETUP_DIFF_BIT = 5;

   // Values after reset
   localparam logic [7:0] STATUS_RST = 8'h03;
   localparam logic [15:0] RESULT_RST = 16'h0000;
   localparam logic [15:0] ZERO_COEF_RST = 16'h8000;
   // Factory scale trim is not known here; plain default
   localparam logic [15:0] SCALE_COEF_RST = 16'h0000;
   localparam logic [7:0] SETUP_RST = 8'h00;
   localparam logic [7:0] RDATA_RST = 8'h00;

   // Arithmetic constants
   localparam logic [15:0] MID_DIFF = 16'h8000;
   localparam logic [15:0] BASE_SINGLE = 16'h3000;
   localparam logic [15:0] RESULT_MAX = 16'hFFF0;

   typedef enum logic [2:0] {
      CDR_MODE_IDLE = 3'b000,
      CDR_MODE_CONT = 3'b001,
      CDR_MODE_SINGLE = 3'b010,
      CDR_MODE_SLEEP = 3'b011,
      CDR_MODE_RSVD4 = 3'b100,
      CDR_MODE_ZERO_CAL = 3'b101,
      CDR_MODE_SCALE_CAL = 3'b110,
      CDR_MODE_RSVD7 = 3'b111
   } cdr_mode_t;

   typedef struct packed {
      logic [1:0] range_sel;
      logic differential_select;
   } cdr_setup_t;

   typedef struct packed {
      logic done;
      logic ch2;
      logic [15:0] code;
   } cdr_conv_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic stop;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cdr_regbus_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic supply_low_or_sleep_flag;
      logic last_channel_flag;
      logic ch2_result_pending_n;
      logic ch1_result_pending_n;
      logic [1:0] rd_busy;
      logic [1:0][15:0] result;
      logic [1:0][15:0] zero_coef;
      logic [1:0][15:0] scale_coef;
      cdr_setup_t [1:0] setup;
   } cdr_state_t;

endpackage

// ---- logic/cdr_regs.sv ----
// Status, result, calibration and setup registers of the capacitance converter
`timescale 1ns/1ps

module cdr_regs
   import cdr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire cdr_regbus_t bus,
   input wire cdr_conv_t conv,
   input wire cdr_mode_t op_mode,
   input wire logic supply_low,
   output logic [7:0] reg_rdata,
   output cdr_setup_t ch1_setup,
   output cdr_setup_t ch2_setup,
   output logic [7:0] status_byte
);

   localparam cdr_state_t STATE_RST = '{
      rdata: RDATA_RST,
      supply_low_or_sleep_flag: STATUS_RST[STAT_SLEEP_BIT],
      last_channel_flag: STATUS_RST[STAT_LAST_CH_BIT],
      ch2_result_pending_n: STATUS_RST[STAT_CH2_PEND_BIT],
      ch1_result_pending_n: STATUS_RST[STAT_CH1_PEND_BIT],
      rd_busy: 2'b00,
      result: {RESULT_RST, RESULT_RST},
      zero_coef: {ZERO_COEF_RST, ZERO_COEF_RST},
      scale_coef: {SCALE_COEF_RST, SCALE_COEF_RST},
      setup: {SETUP_RST[7:5], SETUP_RST[7:5]}
   };

   cdr_state_t s_q;
   cdr_state_t s_d;

   // Which channel's result pair an address hits, if any
   function automatic logic [1:0] result_hit(input logic [7:0] addr);
      logic [1:0] hit;
      hit = 2'b00;
      if (addr == ADDR_CH1_RES_HI || addr == ADDR_CH1_RES_LO) begin
         hit[0] = 1'b1;
      end
      if (addr == ADDR_CH2_RES_HI || addr == ADDR_CH2_RES_LO) begin
         hit[1] = 1'b1;
      end
      return hit;
   endfunction

   // Replace one byte of a 16-bit coefficient
   function automatic logic [15:0] put_byte(input logic [15:0] word, input logic hi,
                                            input logic [7:0] data);
      logic [15:0] w;
      w = word;
      if (hi) begin
         w[15:8] = data;
      end else begin
         w[7:0] = data;
      end
      return w;
   endfunction

   // Offset, scale and midpoint correction of one raw code
   function automatic logic [15:0] correct(input logic [15:0] code,
                                           input logic [15:0] zero,
                                           input logic [15:0] scale,
                                           input logic diff);
      logic [15:0] base;
      logic [15:0] mid;
      logic signed [18:0] delta;
      logic signed [18:0] factor;
      logic signed [37:0] prod;
      logic signed [21:0] sum;
      logic [15:0] res;
      base = diff ? MID_DIFF : BASE_SINGLE;
      mid = diff ? MID_DIFF : 16'h0000;
      delta = $signed({3'b000, code}) - $signed({3'b000, zero}) + $signed({3'b000, base});
      factor = $signed({2'b00, 1'b1, scale});
      prod = delta * factor;
      // Drop 16 fraction bits of the scale factor
      sum = prod[37:16] + $signed({6'b00_0000, mid});
      // Out-of-span codes clip rather than wrap
      if (sum < 0) begin
         res = 16'h0000;
      end else if (sum > $signed({6'b00_0000, RESULT_MAX})) begin
         res = RESULT_MAX;
      end else begin
         res = {sum[15:4], 4'h0};
      end
      return res;
   endfunction

   // Read value of one register byte
   function automatic logic [7:0] read_byte(input cdr_state_t s, input logic [7:0] addr);
      logic [7:0] b;
      b = 8'h00;
      case (addr)
         ADDR_STATUS: begin
            b[STAT_SLEEP_BIT] = s.supply_low_or_sleep_flag;
            b[STAT_LAST_CH_BIT] = s.last_channel_flag;
            b[STAT_CH2_PEND_BIT] = s.ch2_result_pending_n;
            b[STAT_CH1_PEND_BIT] = s.ch1_result_pending_n;
         end
         ADDR_CH1_RES_HI: b = s.result[0][15:8];
         ADDR_CH1_RES_LO: b = s.result[0][7:0];
         ADDR_CH2_RES_HI: b = s.result[1][15:8];
         ADDR_CH2_RES_LO: b = s.result[1][7:0];
         ADDR_CH1_ZERO_HI: b = s.zero_coef[0][15:8];
         ADDR_CH1_ZERO_LO: b = s.zero_coef[0][7:0];
         ADDR_CH2_ZERO_HI: b = s.zero_coef[1][15:8];
         ADDR_CH2_ZERO_LO: b = s.zero_coef[1][7:0];
         ADDR_CH1_SCALE_HI: b = s.scale_coef[0][15:8];
         ADDR_CH1_SCALE_LO: b = s.scale_coef[0][7:0];
         ADDR_CH2_SCALE_HI: b = s.scale_coef[1][15:8];
         ADDR_CH2_SCALE_LO: b = s.scale_coef[1][7:0];
         ADDR_CH1_SETUP: b[7:5] = s.setup[0];
         ADDR_CH2_SETUP: b[7:5] = s.setup[1];
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   logic [1:0] rd_hit;
   logic [1:0] busy_now;
   logic cidx;
   logic conv_diff;
   logic [15:0] corrected;
   logic zero_cal;
   logic measuring;

   always_comb begin
      s_d = s_q;
      rd_hit = bus.rd ? result_hit(bus.addr) : 2'b00;
      // A read in this very cycle already blocks an update
      busy_now = s_q.rd_busy | rd_hit;
      cidx = conv.ch2;
      conv_diff = s_q.setup[cidx].differential_select;
      corrected = correct(conv.code, s_q.zero_coef[cidx], s_q.scale_coef[cidx], conv_diff);
      zero_cal = (op_mode == CDR_MODE_ZERO_CAL);
      measuring = (op_mode == CDR_MODE_CONT) || (op_mode == CDR_MODE_SINGLE);

      s_d.supply_low_or_sleep_flag = supply_low || (op_mode == CDR_MODE_SLEEP);

      if (bus.rd) begin
         s_d.rdata = read_byte(s_q, bus.addr);
      end

      // Busy from first result read to the stop condition
      if (bus.stop) begin
         s_d.rd_busy = 2'b00;
      end
      s_d.rd_busy = s_d.rd_busy | rd_hit;

      // Reading a result consumes its pending flag
      if (rd_hit[0]) begin
         s_d.ch1_result_pending_n = 1'b1;
      end
      if (rd_hit[1]) begin
         s_d.ch2_result_pending_n = 1'b1;
      end

      if (bus.wr) begin
         case (bus.addr)
            ADDR_CH1_ZERO_HI, ADDR_CH1_ZERO_LO: begin
               s_d.zero_coef[0] = put_byte(s_q.zero_coef[0], bus.addr == ADDR_CH1_ZERO_HI,
                                           bus.wdata);
            end
            ADDR_CH2_ZERO_HI, ADDR_CH2_ZERO_LO: begin
               s_d.zero_coef[1] = put_byte(s_q.zero_coef[1], bus.addr == ADDR_CH2_ZERO_HI,
                                           bus.wdata);
            end
            ADDR_CH1_SCALE_HI, ADDR_CH1_SCALE_LO: begin
               s_d.scale_coef[0] = put_byte(s_q.scale_coef[0], bus.addr == ADDR_CH1_SCALE_HI,
                                            bus.wdata);
            end
            ADDR_CH2_SCALE_HI, ADDR_CH2_SCALE_LO: begin
               s_d.scale_coef[1] = put_byte(s_q.scale_coef[1], bus.addr == ADDR_CH2_SCALE_HI,
                                            bus.wdata);
            end
            ADDR_CH1_SETUP: begin
               s_d.setup[0] = bus.wdata[7:5];
            end
            ADDR_CH2_SETUP: begin
               s_d.setup[1] = bus.wdata[7:5];
            end
            default: begin
               s_d.setup = s_d.setup;
            end
         endcase
      end

      if (conv.done) begin
         s_d.last_channel_flag = conv.ch2;
         if (zero_cal) begin
            // Calibration result overrides a host write in the same cycle
            s_d.zero_coef[cidx] = conv.code;
         end else if (measuring && !busy_now[cidx]) begin
            s_d.result[cidx] = corrected;
            // Never meets a same-cycle clear by read: a read of this channel blocks the load and the set
            if (cidx) begin
               s_d.ch2_result_pending_n = 1'b0;
            end else begin
               s_d.ch1_result_pending_n = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign ch1_setup = s_q.setup[0];
   assign ch2_setup = s_q.setup[1];
   assign status_byte = {s_q.supply_low_or_sleep_flag, 4'h0, s_q.last_channel_flag,
                         s_q.ch2_result_pending_n, s_q.ch1_result_pending_n};

endmodule // cdr_regs

// ---- tb/cdr_host.sv ----
// Host-side model of the two-wire slave's register strobes
`timescale 1ns/1ps
module cdr_host
   import cdr_pkg::*;
(
   input wire logic mclk,
   output cdr_regbus_t bus,
   input wire logic [7:0] reg_rdata
);
   initial bus = {3'b000, 16'h5aa5};
   // Released address and data are inverted so stale values never look valid
   task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge mclk);
      bus <= {!w, w, 1'b0, a, d};
      @(posedge mclk);
      bus <= {3'b000, ~a, ~d};
      #1;
      q = reg_rdata;
   endtask
   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      acc(1'b0, a, 8'h00, v[15:8]);
      acc(1'b0, a + 8'h01, 8'h00, v[7:0]);
   endtask
   task automatic stop();
      @(posedge mclk);
      bus.stop <= 1'b1;
      @(posedge mclk);
      bus.stop <= 1'b0;
   endtask
endmodule // cdr_host

// ---- tb/cdr_regs_asserts.sv ----
// Port-level checks for the result and calibration register block
`timescale 1ns/1ps
module cdr_regs_asserts
   import cdr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire cdr_regbus_t bus,
   input wire cdr_conv_t conv,
   input wire cdr_mode_t op_mode,
   input wire logic supply_low,
   input wire logic [7:0] reg_rdata,
   input wire cdr_setup_t ch1_setup,
   input wire cdr_setup_t ch2_setup,
   input wire logic [7:0] status_byte
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic rd1, rd2, busy1_q;
   assign rd1 = bus.rd && bus.addr inside {ADDR_CH1_RES_HI, ADDR_CH1_RES_LO};
   assign rd2 = bus.rd && bus.addr inside {ADDR_CH2_RES_HI, ADDR_CH2_RES_LO};
   // Read span mirrored so a dropped result can be predicted
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b) busy1_q <= 1'b0;
      else busy1_q <= rd1 || (busy1_q && !bus.stop);
   property p_unused_zero;
      status_byte[6:3] == 4'h0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("status unused bits set");
   property p_sleep;
      1'b1 |=> status_byte[7] == $past(supply_low || op_mode == CDR_MODE_SLEEP);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flag wrong");
   property p_rd_status;
      bus.rd && bus.addr == ADDR_STATUS |=> reg_rdata == $past(status_byte);
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("status read mismatch");
   property p_last;
      conv.done |=> status_byte[2] == $past(conv.ch2);
   endproperty
   a_last: assert property (p_last) else $error("last channel flag wrong");
   property p_pend_clr2;
      rd2 && !(conv.done && conv.ch2) |=> status_byte[1];
   endproperty
   a_pend_clr2: assert property (p_pend_clr2) else $error("ch2 pending not cleared");
   property p_setup;
      bus.wr && bus.addr == ADDR_CH1_SETUP |=> ch1_setup == $past(bus.wdata[7:5]);
   endproperty
   a_setup: assert property (p_setup) else $error("ch1 setup not written");
   property p_load1;
      conv.done && !conv.ch2 && op_mode inside {CDR_MODE_CONT, CDR_MODE_SINGLE}
         && !busy1_q && !rd1 |=> !status_byte[0];
   endproperty
   a_load1: assert property (p_load1) else $error("ch1 result not loaded");
   property p_drop1;
      conv.done && !conv.ch2 && busy1_q && status_byte[0] |=> status_byte[0];
   endproperty
   a_drop1: assert property (p_drop1) else $error("ch1 loaded during read");
endmodule // cdr_regs_asserts
bind cdr_regs cdr_regs_asserts u_chk (.mclk(mclk), .rst_b(rst_b), .bus(bus), .conv(conv),
   .op_mode(op_mode), .supply_low(supply_low), .reg_rdata(reg_rdata),
   .ch1_setup(ch1_setup), .ch2_setup(ch2_setup), .status_byte(status_byte));

// ---- tb/cdr_regs_tb.sv ----
// Self-checking bench for the converter result and calibration registers
`timescale 1ns/1ps
module cdr_regs_tb;
   import cdr_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic supply_low = 1'b0;
   cdr_regbus_t bus;
   cdr_conv_t conv = '0;
   cdr_mode_t op_mode = CDR_MODE_IDLE;
   logic [7:0] rdata, status_byte, b, e8;
   logic [15:0] w;
   cdr_setup_t s1, s2;
   int num_errors = 0;
   int num_checks = 0;
   cdr_regs DUT (.mclk(mclk), .rst_b(rst_b), .bus(bus), .conv(conv), .op_mode(op_mode),
      .supply_low(supply_low), .reg_rdata(rdata), .ch1_setup(s1), .ch2_setup(s2),
      .status_byte(status_byte));
   cdr_host host (.mclk(mclk), .bus(bus), .reg_rdata(rdata));
   initial forever #5 mclk = ~mclk;
   task automatic chk(input string n, input logic [15:0] s, e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [15:0] corr(input logic [15:0] c, o, g, input logic d);
      longint v;
      v = longint'(c) - longint'(o) + longint'(d ? MID_DIFF : BASE_SINGLE);
      v = (v * (longint'(g) + longint'(17'h1_0000))) >>> 16;
      v = v + longint'(d ? MID_DIFF : 16'h0000);
      if (v[63]) v = '0;
      if (v > longint'(RESULT_MAX)) v = longint'(RESULT_MAX);
      return v[15:0] & 16'hfff0;
   endfunction
   task automatic cv(input logic c2, input logic [15:0] code);
      @(posedge mclk);
      conv <= {1'b1, c2, code};
      @(posedge mclk);
      conv <= {1'b0, c2, ~code};
      #1;
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      host.acc(1'b1, a, v[15:8], b);
      host.acc(1'b1, a + 8'h01, v[7:0], b);
   endtask
   task automatic res(input logic [7:0] a, input logic [15:0] e);
      host.rd16(a, w);
      chk("pair", w, e);
      host.stop();
   endtask
   task automatic t_regs();
      for (int p = 0; p < 2; p++) begin
         for (int a = 0; a < 17; a++) begin
            host.acc(1'b0, 8'(a), 8'h00, b);
            e8 = a == 0 ? 8'h03 : (a inside {5, 7} && p == 0) ? 8'h80 : 8'h00;
            if (p == 1) e8 = a inside {11, 14} ? 8'he0 : a inside {[5:10], 12, 13} ? 8'hff : e8;
            chk("reg", b, e8);
         end
         host.stop();
         for (int a = 0; a < 17; a++) host.acc(1'b1, 8'(a), 8'hff, b);
      end
      for (int r = 0; r < 4; r++) begin
         host.acc(1'b1, ADDR_CH2_SETUP, {2'(r), 6'h20}, b);
         chk("range", s2, {2'(r), 1'b1});
      end
   endtask
   task automatic t_conv();
      wr16(ADDR_CH1_ZERO_HI, 16'h8000);
      wr16(ADDR_CH1_SCALE_HI, 16'h4000);
      wr16(ADDR_CH2_ZERO_HI, 16'h3000);
      wr16(ADDR_CH2_SCALE_HI, 16'h4000);
      host.acc(1'b1, ADDR_CH1_SETUP, 8'h20, b);
      host.acc(1'b1, ADDR_CH2_SETUP, 8'hc0, b);
      op_mode <= CDR_MODE_CONT;
      cv(1'b0, 16'h9000);
      chk("status", status_byte, 8'h02);
      res(ADDR_CH1_RES_HI, corr(16'h9000, 16'h8000, 16'h4000, 1'b1));
      chk("status", status_byte, 8'h03);
      op_mode <= CDR_MODE_SINGLE;
      cv(1'b1, 16'h3456);
      chk("status", status_byte, 8'h05);
      res(ADDR_CH2_RES_HI, corr(16'h3456, 16'h3000, 16'h4000, 1'b0));
      cv(1'b1, 16'h2000);
      res(ADDR_CH2_RES_HI, corr(16'h2000, 16'h3000, 16'h4000, 1'b0));
      op_mode <= CDR_MODE_CONT;
      host.acc(1'b0, ADDR_CH1_RES_LO, 8'h00, b);
      cv(1'b0, 16'h6000);
      chk("status", status_byte, 8'h03);
      res(ADDR_CH1_RES_HI, 16'hfff0);
      cv(1'b0, 16'h6000);
      res(ADDR_CH1_RES_HI, corr(16'h6000, 16'h8000, 16'h4000, 1'b1));
   endtask
   task automatic t_mode();
      cdr_mode_t ms [3] = '{CDR_MODE_IDLE, CDR_MODE_SLEEP, CDR_MODE_SCALE_CAL};
      op_mode <= CDR_MODE_ZERO_CAL;
      cv(1'b0, 16'h1234);
      res(ADDR_CH1_ZERO_HI, 16'h1234);
      res(ADDR_CH1_RES_HI, 16'hf800);
      foreach (ms[i]) begin
         op_mode <= ms[i];
         cv(1'b1, 16'h0100);
         chk("status", status_byte, {ms[i] == CDR_MODE_SLEEP, 7'h07});
         res(ADDR_CH2_RES_HI, 16'h2800);
      end
      op_mode <= CDR_MODE_IDLE;
      supply_low <= 1'b1;
      cv(1'b0, 16'h0100);
      chk("status", status_byte, 8'h83);
      supply_low <= 1'b0;
   endtask
   task automatic results();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      t_regs();
      t_conv();
      t_mode();
      results();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      results();
   end
endmodule // cdr_regs_tb
